// [rwsc_regs.vh]
// register offsets, field positions, reset values and timing counts for the reset/sleep controller
`ifndef RWSC_REGS_VH
`define RWSC_REGS_VH

`define RWSC_ADDR_WDT_CLEAR 8'he3
`define RWSC_ADDR_STATUS 8'hff
`define RWSC_ADDR_SLEEP_CFG 8'he0
`define RWSC_ADDR_ANALOG_REF 8'he1
`define RWSC_ADDR_STATE 8'he2

`define RWSC_STATUS_POR 8'h10
`define RWSC_BIT_IES 7
`define RWSC_BIT_WATCHDOG_RESET_FLAG 5
`define RWSC_BIT_POWER_ON_FLAG 4
`define RWSC_BIT_SLEEP 3
`define RWSC_BIT_HALT 0

`define RWSC_WDT_CLEAR_ALL 8'h38
`define RWSC_WDT_TERMINAL 2'h3

`define RWSC_CLK_MHZ 200
`define RWSC_SUSPEND_MS 64
`define RWSC_SUSPEND_CYC (`RWSC_SUSPEND_MS * 1000 * `RWSC_CLK_MHZ)
`define RWSC_CAL_CPU_CYCLES 2502
`define RWSC_CAL_CPU_MHZ 3
`define RWSC_CAL_CYC ((`RWSC_CAL_CPU_CYCLES * `RWSC_CLK_MHZ + `RWSC_CAL_CPU_MHZ - 1) / `RWSC_CAL_CPU_MHZ)
`define RWSC_EXTERNAL_RESET_PIN_US 10
`define RWSC_EXTERNAL_RESET_PIN_CYC (`RWSC_EXTERNAL_RESET_PIN_US * `RWSC_CLK_MHZ)

`endif

// [rwsc_reset_watchdog_sleep.v]
// reset sequencer, sleep timer, watchdog chain and sleep control
// How it works
// - power-on reset loads status register with only power-on flag set (0x10)
// - after power-on release hold processor suspended for 64 ms
// - then boot calibration for 2502 cycles at 3 MHz, then run
// - power-on flag set at reset; software may clear, never set
// - external reset pin high at least 10 us forces full power-on reset
// - clearing power-on flag enables watchdog; only power-on reset disables it
// - sleep timer divides slow clock; four selectable period multiples
// - each sleep timer overflow raises sleep interrupt, asleep or awake
// - watchdog counts overflows; at three it fires watchdog reset
// - any clear-register write clears watchdog; 38h also clears sleep timer
// - crystal selected switches slow clock source at next sleep interrupt
// - sleep bit stops processor until interrupt pending or reset
// - during sleep gate all main-oscillator derived clocks
// - clearing analog power bits powers down analog; setting restores enables
// - interrupts stay active while asleep; only interrupt wakes
// - resume from sleep only when halt bit is clear
// - on wake restart oscillator; hold off one slow cycle with PLL, else half
// - crystal selected disables internal slow oscillator, crystal runs in sleep
// - during sleep stop digital blocks not on slow clock or pin
// - any reset restores defaults, disables interrupts, restarts, minimum interval
// - watchdog reset sets flag bit 5; software may clear, never set
// - status bits: 7 ies, 5 watchdog, 4 power-on, 3 sleep, 0 halt
`timescale 1ns/1ps
`include "rwsc_regs.vh"

module rwsc_reset_watchdog_sleep #(
	parameter SUSPEND_CYC = `RWSC_SUSPEND_CYC,
	parameter CAL_CYC = `RWSC_CAL_CYC,
	parameter EXTERNAL_RESET_PIN_CYC = `RWSC_EXTERNAL_RESET_PIN_CYC
) (
	// clock, reset, enable
	input wire clk,
	input wire reset,
	input wire clkEn,
	// register port
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdData,
	// pins and sources
	input wire externalResetPin,
	input wire slowClockIn,
	input wire crystalClockIn,
	input wire interruptPending,
	input wire cpuIntEnable,
	// controls out
	output reg cpuRun,
	output reg cpuRestart,
	output reg mainClockGate,
	output reg analogPowerOn,
	output reg internalSlowOscOn,
	output reg slowClockSelCrystal,
	output reg sleepInterrupt,
	output reg watchdogResetEvent
);

localparam ST_SUSPEND = 3'h0;
localparam ST_CAL = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_SLEEP = 3'h3;
localparam ST_HOLD = 3'h4;
localparam ST_HALT = 3'h5;

function [7:0] intervalTicks;
	input [1:0] sel;
	begin
		case (sel)
			2'h0: intervalTicks = 8'h40;
			2'h1: intervalTicks = 8'h80;
			2'h2: intervalTicks = 8'hc0;
			default: intervalTicks = 8'hff;
		endcase
	end
endfunction

// write-address decode shared by every writable register; reads decode by case
function regHit;
	input [7:0] addr;
	input [7:0] target;
	input strobe;
	begin
		regHit = strobe && (addr == target);
	end
endfunction

// last count of each timed phase, sized to the counter that meets it
localparam [27:0] SUSPEND_LAST = SUSPEND_CYC - 1;
localparam [27:0] CAL_LAST = CAL_CYC - 1;
localparam [15:0] EXTERNAL_RESET_PIN_LAST = EXTERNAL_RESET_PIN_CYC - 1;

////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, change counted when 2nd and 3rd agree
reg [2:0] xresSync_ff;
reg [2:0] slowSync_ff;
reg [2:0] xtalSync_ff;
reg xresLevel_ff;
reg slowLevel_ff;
reg slowPrev_ff;
reg [15:0] xresCnt_ff;
reg xresPor_ff;

wire slowSrc = slowClockSelCrystal ? xtalSync_ff[2] : slowSync_ff[2];
wire slowAgree = slowClockSelCrystal ? (xtalSync_ff[2] == xtalSync_ff[1]) :
	(slowSync_ff[2] == slowSync_ff[1]);
wire slowRise = slowLevel_ff & ~slowPrev_ff;
wire slowFall = ~slowLevel_ff & slowPrev_ff;

always @(posedge clk) begin
	if (reset) begin
		xresSync_ff <= 3'h0;
		slowSync_ff <= 3'h0;
		xtalSync_ff <= 3'h0;
		xresLevel_ff <= 1'b0;
		slowLevel_ff <= 1'b0;
		slowPrev_ff <= 1'b0;
		xresCnt_ff <= 16'h0;
		xresPor_ff <= 1'b0;
	end else if (clkEn) begin
		xresSync_ff <= {xresSync_ff[1:0], externalResetPin};
		slowSync_ff <= {slowSync_ff[1:0], slowClockIn};
		xtalSync_ff <= {xtalSync_ff[1:0], crystalClockIn};
		if (xresSync_ff[2] == xresSync_ff[1]) begin
			xresLevel_ff <= xresSync_ff[2];
		end
		if (slowAgree) begin
			slowLevel_ff <= slowSrc;
		end
		slowPrev_ff <= slowLevel_ff;
		// counter parks at the end, so reset lasts as long as the pin stays high
		xresPor_ff <= 1'b0;
		if (!xresLevel_ff) begin
			xresCnt_ff <= 16'h0;
		end else if (xresCnt_ff == EXTERNAL_RESET_PIN_LAST) begin
			xresPor_ff <= 1'b1;
		end else begin
			xresCnt_ff <= xresCnt_ff + 16'h1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// registers and sequencer
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [27:0] seqCnt_ff;
reg porsFlag_ff;
reg wdrsFlag_ff;
reg sleepBit_ff;
reg haltBit_ff;
reg wdtEnable_ff;
reg [1:0] wdtCnt_ff;
reg [7:0] sleepCnt_ff;
reg [1:0] intervalSel_ff;
reg pllEnable_ff;
reg crystalSelect_ff;
reg analogPower_ff;
reg [3:0] analogEnables_ff;
reg [3:0] analogOn_ff;
reg wdrPending_ff;

wire por = xresPor_ff;
wire wdtWr = regHit(regAddr, `RWSC_ADDR_WDT_CLEAR, regWrite);
wire statusWr = regHit(regAddr, `RWSC_ADDR_STATUS, regWrite);
wire cfgWr = regHit(regAddr, `RWSC_ADDR_SLEEP_CFG, regWrite);
wire anaWr = regHit(regAddr, `RWSC_ADDR_ANALOG_REF, regWrite);
wire wdtClearAll = wdtWr && regWrData == `RWSC_WDT_CLEAR_ALL;
wire sleepOverflow = slowRise && (sleepCnt_ff == intervalTicks(intervalSel_ff) - 8'h1);
wire wdtFire = wdtEnable_ff && sleepOverflow && !wdtWr &&
	wdtCnt_ff == `RWSC_WDT_TERMINAL - 2'h1;
wire anyReset = por || wdrPending_ff;
wire holdDone = pllEnable_ff ? slowRise : (slowRise || slowFall);

always @* begin
	nxt_state = state_ff;
	case (state_ff)
		ST_SUSPEND: begin
			// supply settle time before calibration
			if (seqCnt_ff == SUSPEND_LAST) begin
				nxt_state = ST_CAL;
			end
		end
		ST_CAL: begin
			// calibration time at the processor's boot clock rate
			if (seqCnt_ff == CAL_LAST) begin
				nxt_state = ST_RUN;
			end
		end
		ST_RUN: begin
			// halt wins over sleep when both bits are written together
			if (haltBit_ff) begin
				nxt_state = ST_HALT;
			end else if (sleepBit_ff) begin
				nxt_state = ST_SLEEP;
			end
		end
		ST_SLEEP: begin
			// only a pending interrupt wakes, and never while halted
			if (interruptPending && !haltBit_ff) begin
				nxt_state = ST_HOLD;
			end
		end
		ST_HOLD: begin
			if (holdDone) begin
				nxt_state = ST_RUN;
			end
		end
		ST_HALT: begin
			// left only through a reset
			nxt_state = ST_HALT;
		end
		default: begin
			// unused codes fall back to the start of the sequence
			nxt_state = ST_SUSPEND;
		end
	endcase
end

always @(posedge clk) begin
	if (reset) begin
		state_ff <= ST_SUSPEND;
		seqCnt_ff <= 28'h0;
		porsFlag_ff <= 1'b1;
		wdrsFlag_ff <= 1'b0;
		sleepBit_ff <= 1'b0;
		haltBit_ff <= 1'b0;
		wdtEnable_ff <= 1'b0;
		wdtCnt_ff <= 2'h0;
		sleepCnt_ff <= 8'h0;
		intervalSel_ff <= 2'h0;
		pllEnable_ff <= 1'b0;
		crystalSelect_ff <= 1'b0;
		analogPower_ff <= 1'b1;
		analogEnables_ff <= 4'h0;
		wdrPending_ff <= 1'b0;
		slowClockSelCrystal <= 1'b0;
		sleepInterrupt <= 1'b0;
		watchdogResetEvent <= 1'b0;
	end else if (clkEn) begin
		sleepInterrupt <= 1'b0;
		watchdogResetEvent <= 1'b0;
		wdrPending_ff <= wdtFire;
		if (anyReset) begin
			state_ff <= ST_SUSPEND;
			seqCnt_ff <= 28'h0;
			porsFlag_ff <= por ? 1'b1 : porsFlag_ff;
			wdrsFlag_ff <= por ? 1'b0 : 1'b1;
			wdtEnable_ff <= por ? 1'b0 : wdtEnable_ff;
			sleepBit_ff <= 1'b0;
			haltBit_ff <= 1'b0;
			wdtCnt_ff <= 2'h0;
			sleepCnt_ff <= 8'h0;
			intervalSel_ff <= 2'h0;
			pllEnable_ff <= 1'b0;
			crystalSelect_ff <= 1'b0;
			analogPower_ff <= 1'b1;
			analogEnables_ff <= 4'h0;
			slowClockSelCrystal <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			seqCnt_ff <= (nxt_state != state_ff) ? 28'h0 : seqCnt_ff + 28'h1;
			if (statusWr) begin
				if (!regWrData[`RWSC_BIT_POWER_ON_FLAG]) begin
					porsFlag_ff <= 1'b0;
					wdtEnable_ff <= 1'b1;
				end
				// ones in the flag bits are ignored: flags clear, never set
				if (!regWrData[`RWSC_BIT_WATCHDOG_RESET_FLAG]) begin
					wdrsFlag_ff <= 1'b0;
				end
				haltBit_ff <= regWrData[`RWSC_BIT_HALT];
				sleepBit_ff <= regWrData[`RWSC_BIT_SLEEP];
			end else if (state_ff == ST_SLEEP && nxt_state == ST_HOLD) begin
				sleepBit_ff <= 1'b0;
			end
			if (cfgWr) begin
				intervalSel_ff <= regWrData[1:0];
				pllEnable_ff <= regWrData[2];
				crystalSelect_ff <= regWrData[3];
			end
			if (anaWr) begin
				analogPower_ff <= regWrData[7];
				analogEnables_ff <= regWrData[3:0];
			end
			if (wdtClearAll) begin
				sleepCnt_ff <= 8'h0;
			end else if (slowRise) begin
				sleepCnt_ff <= sleepOverflow ? 8'h0 : sleepCnt_ff + 8'h1;
			end
			if (sleepOverflow && !wdtClearAll) begin
				sleepInterrupt <= 1'b1;
				// switch only on an overflow so the crystal has had an interval to start
				if (crystalSelect_ff) begin
					slowClockSelCrystal <= 1'b1;
				end
			end
			// a software clear wins over a same-cycle increment
			if (wdtWr) begin
				wdtCnt_ff <= 2'h0;
			end else if (wdtEnable_ff && sleepOverflow && !wdtClearAll) begin
				wdtCnt_ff <= wdtCnt_ff + 2'h1;
			end
			if (wdtFire) begin
				watchdogResetEvent <= 1'b1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// clock gating, analog power and readback
wire asleep = state_ff == ST_SLEEP;

// readback images; status bit 7 mirrors the processor's own enable flag
wire [7:0] statusByte = {cpuIntEnable, 1'b0, wdrsFlag_ff, porsFlag_ff, sleepBit_ff, 2'h0,
	haltBit_ff};
wire [7:0] cfgByte = {4'h0, crystalSelect_ff, pllEnable_ff, intervalSel_ff};
wire [7:0] analogByte = {analogPower_ff, 3'h0, analogOn_ff};
wire [7:0] stateByte = {wdtEnable_ff, wdtCnt_ff, slowClockSelCrystal, 1'b0, state_ff};

always @(posedge clk) begin
	if (reset) begin
		cpuRun <= 1'b0;
		cpuRestart <= 1'b1;
		mainClockGate <= 1'b1;
		analogPowerOn <= 1'b1;
		internalSlowOscOn <= 1'b1;
		analogOn_ff <= 4'h0;
		regRdData <= 8'h0;
	end else if (clkEn) begin
		cpuRun <= state_ff == ST_RUN && !anyReset;
		cpuRestart <= anyReset || state_ff == ST_SUSPEND;
		mainClockGate <= !asleep;
		analogPowerOn <= analogPower_ff;
		analogOn_ff <= analogPower_ff ? analogEnables_ff : 4'h0;
		// stays off once the crystal drives the slow clock, even if deselected
		internalSlowOscOn <= !(crystalSelect_ff || slowClockSelCrystal);

		regRdData <= 8'h0;
		if (regRead) begin
			case (regAddr)
				`RWSC_ADDR_STATUS: begin
					regRdData <= statusByte;
				end
				`RWSC_ADDR_SLEEP_CFG: begin
					regRdData <= cfgByte;
				end
				`RWSC_ADDR_ANALOG_REF: begin
					regRdData <= analogByte;
				end
				`RWSC_ADDR_STATE: begin
					regRdData <= stateByte;
				end
				default: begin
					regRdData <= 8'h0;
				end
			endcase
		end
	end
end

endmodule

// [rwsc_slow_src.sv]
// far-side model: internal slow oscillator and crystal sources
`timescale 1ns/1ps
module rwsc_slow_src (
	// slow clock sources
	output logic slowClk,
	output logic xtalClk
);
	// free-running and unrelated to clk, as the real oscillators are
	initial begin
		slowClk = 1'b0;
		forever #20 slowClk = ~slowClk;
	end
	initial begin
		xtalClk = 1'b0;
		forever #17.3 xtalClk = ~xtalClk;
	end
endmodule

// [rwsc_reset_watchdog_sleep_monitor.sv]
// port-level checker for the reset/sleep controller
`timescale 1ns/1ps
module rwsc_monitor #(
	parameter int SUSPEND_CYC = 20,
	parameter int CAL_CYC = 10
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// register port
	input wire regRead,
	input wire [7:0] regRdData,
	// controls
	input wire cpuRun,
	input wire cpuRestart,
	input wire mainClockGate,
	input wire internalSlowOscOn,
	input wire slowClockSelCrystal,
	input wire sleepInterrupt,
	input wire watchdogResetEvent
);
	localparam int HOLD_MAX = SUSPEND_CYC + CAL_CYC + 8;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence heldOff;
		!cpuRun [*8];
	endsequence
	sequence restarted;
		cpuRestart && !cpuRun;
	endsequence
	rd_idle_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data present without a read");
	por_hold_a: assert property ($fell(reset) |-> heldOff ##[1:HOLD_MAX] cpuRun)
		else $error("processor start after reset out of bounds");
	int_pulse_a: assert property (sleepInterrupt |=> !sleepInterrupt)
		else $error("sleep interrupt longer than one cycle");
	wdr_restart_a: assert property (watchdogResetEvent |-> ##[0:2] restarted)
		else $error("watchdog reset did not restart processor");
	sleep_stop_a: assert property (!mainClockGate |-> !cpuRun)
		else $error("processor runs with main clocks gated");
	wake_hold_a: assert property ($rose(mainClockGate) |-> !cpuRun)
		else $error("no hold-off on wake");
	xtal_osc_a: assert property (slowClockSelCrystal |-> !internalSlowOscOn)
		else $error("internal slow oscillator left on");
	reset_dflt_a: assert property (disable iff (1'b0) reset |=> restarted and mainClockGate)
		else $error("reset defaults wrong");
endmodule
bind rwsc_reset_watchdog_sleep rwsc_monitor #(.SUSPEND_CYC(SUSPEND_CYC), .CAL_CYC(CAL_CYC)) mon_u (
	.clk(clk), .reset(reset), .regRead(regRead), .regRdData(regRdData), .cpuRun(cpuRun),
	.cpuRestart(cpuRestart), .mainClockGate(mainClockGate), .internalSlowOscOn(internalSlowOscOn),
	.slowClockSelCrystal(slowClockSelCrystal), .sleepInterrupt(sleepInterrupt),
	.watchdogResetEvent(watchdogResetEvent));

// [rwsc_reset_watchdog_sleep_tb.sv]
// self-checking bench for the reset/sleep controller
`timescale 1ns/1ps
`include "rwsc_regs.vh"
module rwsc_reset_watchdog_sleep_tb;
	localparam int SUSP = 20;
	localparam int CAL = 10;
	logic clk = 0, reset = 1, regWrite = 0, regRead = 0, extPin = 0, intPend = 0, ies = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
	wire [7:0] regRdData;
	wire slowClk, xtalClk, cpuRun, cpuRestart, mainGate, anaOn, slowOsc, selXtal, sleepInt, wdrEv;
	int errors = 0, samples_checked = 0, cycles = 0, ovf = 0, ovfAtWdr = -1, n, t;
	int porsM = 1, wdrsM = 0;
	int ticks[4] = '{64, 128, 192, 255};
	rwsc_slow_src src_u (.slowClk(slowClk), .xtalClk(xtalClk));
	rwsc_reset_watchdog_sleep #(.SUSPEND_CYC(SUSP), .CAL_CYC(CAL), .EXTERNAL_RESET_PIN_CYC(8)) dut_u (
		.clk(clk), .reset(reset), .clkEn(1'b1), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.externalResetPin(extPin), .slowClockIn(slowClk), .crystalClockIn(xtalClk),
		.interruptPending(intPend), .cpuIntEnable(ies), .cpuRun(cpuRun),
		.cpuRestart(cpuRestart), .mainClockGate(mainGate), .analogPowerOn(anaOn),
		.internalSlowOscOn(slowOsc), .slowClockSelCrystal(selXtal),
		.sleepInterrupt(sleepInt), .watchdogResetEvent(wdrEv));
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] stat();
		return {ies, 1'b0, wdrsM[0], porsM[0], 4'h0};
	endfunction
	task automatic test_done();
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regRdData & m, exp);
	endtask
	// bounded wait for a run or an overflow pulse; pulses stand one cycle
	task automatic waitFor(input bit onInt, output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1 c++;
		end while ((onInt ? sleepInt : cpuRun) !== 1'b1 && c < 3000);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (sleepInt === 1'b1)
			ovf <= ovf + 1;
		if (wdrEv === 1'b1 && ovfAtWdr < 0)
			ovfAtWdr <= ovf + 1;
		if (cycles == 40000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		void'($urandom(1559));
		@(posedge clk);
		ies <= 1'($urandom);
		repeat (9) @(posedge clk);
		reset <= 1'b0;
		waitFor(0, n);
		chk(8'(n >= SUSP + CAL - 1 && n < 500), 8'h01);
		rdc(`RWSC_ADDR_STATUS, 8'hff, stat());
		wr(`RWSC_ADDR_STATUS, 8'h30);
		rdc(`RWSC_ADDR_STATUS, 8'hff, stat());
		rdc(`RWSC_ADDR_WDT_CLEAR, 8'hff, 8'h00);
		rdc(8'he5, 8'hff, 8'h00);
		wr(`RWSC_ADDR_ANALOG_REF, 8'h05);
		rdc(`RWSC_ADDR_ANALOG_REF, 8'hff, 8'h00);
		wr(`RWSC_ADDR_STATUS, 8'h18);
		repeat (60) @(posedge clk);
		#1 chk({5'h0, anaOn, mainGate, cpuRun}, 8'h00);
		@(posedge clk);
		intPend <= 1'b1;
		waitFor(0, n);
		intPend <= 1'b0;
		chk({6'h0, mainGate, 1'(n < 40)}, 8'h03);
		rdc(`RWSC_ADDR_STATUS, 8'hff, stat());
		wr(`RWSC_ADDR_ANALOG_REF, 8'h85);
		rdc(`RWSC_ADDR_ANALOG_REF, 8'hff, 8'h85);
		for (int c = 0; c < 4; c++) begin
			wr(`RWSC_ADDR_SLEEP_CFG, 8'(c));
			rdc(`RWSC_ADDR_SLEEP_CFG, 8'h03, 8'(c));
			waitFor(1, n);
			waitFor(1, t);
			chk(8'(t >= ticks[c] * 8 - 2 && t <= ticks[c] * 8 + 2), 8'h01);
		end
		wr(`RWSC_ADDR_SLEEP_CFG, 8'h00);
		wr(`RWSC_ADDR_STATUS, 8'h00);
		porsM = 0;
		wr(`RWSC_ADDR_STATUS, 8'h10);
		rdc(`RWSC_ADDR_STATUS, 8'hff, stat());
		rdc(`RWSC_ADDR_STATE, 8'h80, 8'h80);
		repeat (8) begin
			repeat (200) @(posedge clk);
			wr(`RWSC_ADDR_WDT_CLEAR, 8'($urandom));
		end
		chk(8'(ovfAtWdr < 0), 8'h01);
		wr(`RWSC_ADDR_WDT_CLEAR, `RWSC_WDT_CLEAR_ALL);
		n = ovf;
		for (t = 0; ovfAtWdr < 0 && t < 3000; t++)
			@(posedge clk);
		chk(8'(ovfAtWdr - n), 8'h03);
		wdrsM = 1;
		rdc(`RWSC_ADDR_STATUS, 8'hff, stat());
		rdc(`RWSC_ADDR_STATE, 8'h80, 8'h80);
		wr(`RWSC_ADDR_STATUS, 8'h00);
		wdrsM = 0;
		foreach (ticks[i]) begin
			@(posedge clk);
			extPin <= 1'b1;
			repeat (i * 4 + 2) @(posedge clk);
			extPin <= 1'b0;
			porsM = (i * 4 + 2 >= 8) ? 1 : porsM;
			repeat (4) @(posedge clk);
			rdc(`RWSC_ADDR_STATUS, 8'hff, stat());
		end
		rdc(`RWSC_ADDR_STATE, 8'h80, 8'h00);
		wr(`RWSC_ADDR_SLEEP_CFG, 8'h0b);
		#1 chk({6'h0, selXtal, slowOsc}, 8'h01);
		waitFor(1, n);
		repeat (6) @(posedge clk);
		#1 chk({6'h0, selXtal, slowOsc}, 8'h02);
		test_done();
	end
endmodule
